// ---- rtl/core_mem_pkg.sv ----
// package: constants, types and register map of the core memory block
// assumes a single core clock and a synchronous active-low reset
package core_mem_pkg;
  // core register offsets and region limits within every bank
  localparam logic [6:0] OFF_INDIRECT_DATA_0 = 7'h00;
  localparam logic [6:0] OFF_INDIRECT_DATA_1 = 7'h01;
  localparam logic [6:0] OFF_PCL = 7'h02;
  localparam logic [6:0] OFF_STATUS = 7'h03;
  localparam logic [6:0] OFF_PTR0L = 7'h04;
  localparam logic [6:0] OFF_PTR0H = 7'h05;
  localparam logic [6:0] OFF_PTR1L = 7'h06;
  localparam logic [6:0] OFF_PTR1H = 7'h07;
  localparam logic [6:0] OFF_BSR = 7'h08;
  localparam logic [6:0] OFF_WORKING_REGISTER = 7'h09;
  localparam logic [6:0] OFF_PROGRAM_COUNTER_LATCH_HIGH = 7'h0A;
  localparam logic [6:0] OFF_INTERRUPT_CONTROL = 7'h0B;
  localparam logic [6:0] OFF_CORE_END = 7'h0B;
  localparam logic [6:0] OFF_SFR_END = 7'h1F;
  localparam logic [6:0] OFF_GPR_END = 7'h6F;
  localparam logic [6:0] OFF_COMMON = 7'h70;
  // sizes, vectors and program memory masks
  localparam int STACK_DEPTH = 16;
  localparam int PC_W = 15;
  localparam int GPR_BYTES = 80;
  localparam int BANKS = 32;
  localparam int COMMON_BYTES = 16;
  localparam logic [PC_W-1:0] RESET_VEC = 15'h0000;
  localparam logic [PC_W-1:0] IRQ_VEC = 15'h0004;
  localparam logic [PC_W-1:0] PM_MASK_SMALL = 15'h03FF;
  localparam logic [PC_W-1:0] PM_MASK_LARGE = 15'h07FF;
  localparam logic [PC_W-1:0] HEF_SPAN = 15'h007F;
  // status bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam logic [7:0] STATUS_RST = 8'h18;
  // unified pointer space
  localparam int PTR_PM_BIT = 15;
  localparam logic [15:0] LIN_BASE = 16'h2000;
  localparam logic [15:0] LIN_TOP = 16'h29AF;

  // one data-memory access request from the execution pipeline
  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic alu_flags;
    logic [2:0] flags;
  } dmem_req_t;

  // stack control from the execution pipeline
  typedef struct packed {
    logic push;
    logic pop;
    logic [PC_W-1:0] ret_pc;
  } stack_req_t;
endpackage : core_mem_pkg

// ---- rtl/core_memory_addressing.sv ----
// core memory addressing: stack, pointers, banked data decode, status
// assumes the pipeline presents one access per cycle and waits on stall
// Contract
// RULE1: return stack is 16 entries of 15 bits
// RULE2: overflow/underflow set flags; reset when enabled
// RULE3: two 16-bit pointers reach data and program memory
// RULE4: program-memory indirect reads take one extra cycle
// RULE5: program counter is 15 bits wide
// RULE6: program addresses wrap into implemented size
// RULE7: reset starts at 0000h, interrupt jumps to 0004h
// RULE8: last 128 words form the high-endurance region
// RULE9: pointer bit 15 set makes indirect read fetch program low byte
// RULE10: indirect writes to program memory are dropped
// RULE11: 32 banks of 128 bytes, core, peripheral, ram, common
// RULE12: direct accesses use the bank select register
// RULE13: unimplemented data locations read zero
// RULE14: 12-bit address: 5 bank bits, 7 offset bits
// RULE15: first 12 locations of each bank are core registers
// RULE16: flag-affecting writes to status keep alu flags
// RULE17: timeout and powerdown flags ignore software writes
// RULE18: clear of status zeros top bits and sets zero flag
// RULE19: software should alter status only with flag-neutral ops
// RULE20: carry flags are inverted borrows on subtraction
// RULE21: interrupt entry shadows core registers, return restores
// RULE22: pointers give a linear view of general ram
// RULE23: timeout cleared on watchdog expiry, set on clear or sleep
// RULE24: peripheral registers sit at offsets 0Ch to 1Fh
// RULE25: indirect data accesses go to the paired pointer target
`timescale 1ns/100ps
`default_nettype none
module core_memory_addressing #(
  parameter bit LARGE_PM = 1'b0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // data access
  input wire core_mem_pkg::dmem_req_t req,
  output logic [7:0] rdata,
  output logic stall,
  // stack and flow
  input wire core_mem_pkg::stack_req_t stk,
  output logic [14:0] stack_top,
  input wire logic irq_take,
  input wire logic irq_return,
  input wire logic [14:0] pc_next,
  output logic [14:0] pc,
  output logic stack_rst_en_in_unused,
  // reset control
  input wire logic stack_reset_enable,
  output logic soft_reset,
  output logic stack_overflow_flag,
  output logic stack_underflow_flag,
  input wire logic [1:0] flag_clear,
  // watchdog and power
  input wire logic wdt_expire,
  input wire logic wdt_clear,
  input wire logic sleep_exec,
  // program memory read port
  output logic [14:0] pm_addr,
  output logic pm_rd,
  input wire logic [13:0] pm_data,
  output logic pm_in_hef,
  // peripheral register port
  output logic [11:0] sfr_addr,
  output logic sfr_rd,
  output logic sfr_wr,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_PMWAIT = 2'b10
  } pm_state_t;

  logic [14:0] stack_mem [core_mem_pkg::STACK_DEPTH];
  logic [4:0] sp_r;
  logic [15:0] ptr0_r, ptr1_r;
  logic [7:0] bsr_r, working_register_r, program_counter_latch_high_r, interrupt_control_r, status_r;
  logic [14:0] pc_r;
  logic ovf_r, unf_r, srst_r;
  logic [7:0] general_ram [core_mem_pkg::BANKS*core_mem_pkg::GPR_BYTES];
  logic [7:0] common [core_mem_pkg::COMMON_BYTES];
  logic [7:0] sh_status_r, sh_working_register_r, sh_bsr_r, sh_program_counter_latch_high_r;
  logic [15:0] sh_ptr0_r, sh_ptr1_r;
  pm_state_t pm_st_r, pm_st_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  function automatic logic [14:0] wrap_pc(input logic [14:0] a);
    wrap_pc = a & (LARGE_PM ? core_mem_pkg::PM_MASK_LARGE
                            : core_mem_pkg::PM_MASK_SMALL);
  endfunction : wrap_pc

  // full 12-bit data address: bank in bits 11:7, offset in 6:0
  function automatic logic [11:0] gpr_index_ok(input logic [11:0] a);
    gpr_index_ok = a;
  endfunction : gpr_index_ok

  assign stack_rst_en_in_unused = 1'b0;

  // RULE25 indirect redirect
  wire is_ind0 = req.addr == core_mem_pkg::OFF_INDIRECT_DATA_0;
  wire is_ind1 = req.addr == core_mem_pkg::OFF_INDIRECT_DATA_1;
  wire is_ind = is_ind0 | is_ind1;
  wire [15:0] ptr_sel = is_ind1 ? ptr1_r : ptr0_r;
  // RULE9 program memory select
  wire ptr_pm = is_ind && ptr_sel[core_mem_pkg::PTR_PM_BIT];
  // RULE22 linear window
  wire ptr_lin = is_ind && !ptr_pm &&
    ptr_sel >= core_mem_pkg::LIN_BASE && ptr_sel <= core_mem_pkg::LIN_TOP;
  wire [15:0] lin_off = ptr_sel - core_mem_pkg::LIN_BASE;
  // RULE13 pointer values beyond the banked space and the window read zero
  wire ptr_hole = is_ind && !ptr_pm && !ptr_lin && ptr_sel[14:12] != 3'h0;
  // RULE12 RULE14 effective address
  wire [11:0] eff_addr = is_ind ? ptr_sel[11:0] : {bsr_r[4:0], req.addr};
  wire [6:0] off = eff_addr[6:0];
  wire [4:0] bank = eff_addr[11:7];
  // RULE15 RULE24 RULE11 region decode
  wire in_core = off <= core_mem_pkg::OFF_CORE_END;
  wire in_sfr = !in_core && off <= core_mem_pkg::OFF_SFR_END;
  wire in_gpr = !in_core && !in_sfr && off <= core_mem_pkg::OFF_GPR_END;
  wire in_com = off >= core_mem_pkg::OFF_COMMON;
  wire ind_of_ind = is_ind && in_core &&
    (off == core_mem_pkg::OFF_INDIRECT_DATA_0 || off == core_mem_pkg::OFF_INDIRECT_DATA_1);
  wire [11:0] gpr_idx = ptr_lin ? lin_off[11:0]
    : 12'(bank) * 12'(core_mem_pkg::GPR_BYTES) +
      12'(off - (core_mem_pkg::OFF_SFR_END + 7'h01));
  wire [3:0] com_idx = off[3:0];
  wire use_gpr = ptr_lin || (!ptr_pm && !ptr_hole && in_gpr);
  wire use_com = !ptr_lin && !ptr_pm && !ptr_hole && in_com;
  wire use_core = !ptr_lin && !ptr_pm && !ptr_hole && in_core &&
    !ind_of_ind;
  wire do_wr = req.wr && !ptr_pm;

  // RULE4 one extra cycle on program memory indirect
  assign stall = (pm_st_r == ST_IDLE) && req.rd && ptr_pm;
  always_comb begin
    pm_st_nxt = ST_IDLE;
    unique case (pm_st_r)
      ST_IDLE: pm_st_nxt = stall ? ST_PMWAIT : ST_IDLE;
      ST_PMWAIT: pm_st_nxt = ST_IDLE;
      default: pm_st_nxt = ST_IDLE;
    endcase
  end

  // RULE6 wrapped program address; RULE8 high-endurance flag
  assign pm_addr = ptr_pm ? wrap_pc(ptr_sel[14:0]) : wrap_pc(pc_r);
  assign pm_rd = stall;
  wire [14:0] pm_top = LARGE_PM ? core_mem_pkg::PM_MASK_LARGE
                                : core_mem_pkg::PM_MASK_SMALL;
  assign pm_in_hef = pm_addr >= (pm_top - core_mem_pkg::HEF_SPAN);

  // core register read mux
  logic [7:0] core_rd;
  always_comb begin
    core_rd = 8'h00;
    unique case (off)
      core_mem_pkg::OFF_PCL: core_rd = pc_r[7:0];
      core_mem_pkg::OFF_STATUS: core_rd = status_r;
      core_mem_pkg::OFF_PTR0L: core_rd = ptr0_r[7:0];
      core_mem_pkg::OFF_PTR0H: core_rd = ptr0_r[15:8];
      core_mem_pkg::OFF_PTR1L: core_rd = ptr1_r[7:0];
      core_mem_pkg::OFF_PTR1H: core_rd = ptr1_r[15:8];
      core_mem_pkg::OFF_BSR: core_rd = bsr_r;
      core_mem_pkg::OFF_WORKING_REGISTER: core_rd = working_register_r;
      core_mem_pkg::OFF_PROGRAM_COUNTER_LATCH_HIGH: core_rd = program_counter_latch_high_r;
      core_mem_pkg::OFF_INTERRUPT_CONTROL: core_rd = interrupt_control_r;
      default: core_rd = 8'h00;
    endcase
  end

  // RULE13 unimplemented reads zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (pm_st_r == ST_PMWAIT) begin
      rdata_nxt = pm_data[7:0];
    end else if (req.rd && !ptr_pm) begin
      if (use_gpr && gpr_idx < 12'(core_mem_pkg::BANKS *
          core_mem_pkg::GPR_BYTES)) begin
        rdata_nxt = general_ram[gpr_idx];
      end else if (use_com) begin
        rdata_nxt = common[com_idx];
      end else if (use_core) begin
        rdata_nxt = core_rd;
      end else if (!ptr_lin && !ptr_hole && in_sfr) begin
        rdata_nxt = sfr_rdata;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end
  assign rdata = rdata_r;

  assign sfr_addr = eff_addr;
  assign sfr_rd = req.rd && !ptr_pm && !ptr_lin && !ptr_hole && in_sfr;
  assign sfr_wr = do_wr && !ptr_lin && !ptr_hole && in_sfr;
  assign sfr_wdata = req.wdata;

  // RULE16 RULE17 RULE18 RULE20 status write merge
  wire st_wr = do_wr && use_core && off == core_mem_pkg::OFF_STATUS;
  logic [7:0] st_nxt;
  always_comb begin
    st_nxt = status_r;
    if (st_wr) begin
      st_nxt[2:0] = req.alu_flags ? status_r[2:0] : req.wdata[2:0];
    end
    if (req.alu_flags) begin
      st_nxt[2:0] = req.flags;
    end
    // RULE23 timeout and powerdown hardware control
    if (wdt_expire) begin
      st_nxt[core_mem_pkg::ST_TO] = 1'b0;
    end else if (wdt_clear || sleep_exec) begin
      st_nxt[core_mem_pkg::ST_TO] = 1'b1;
    end
    if (sleep_exec) begin
      st_nxt[core_mem_pkg::ST_PD] = 1'b0;
    end else if (wdt_clear) begin
      st_nxt[core_mem_pkg::ST_PD] = 1'b1;
    end
    st_nxt[7:5] = 3'h0;
  end

  // RULE1 RULE2 stack pointer and fault detection
  wire push_ovf = stk.push && sp_r == 5'(core_mem_pkg::STACK_DEPTH);
  wire pop_unf = stk.pop && sp_r == 5'h00;
  assign stack_top = (sp_r == 5'h00) ? core_mem_pkg::RESET_VEC
                                     : stack_mem[4'(sp_r - 5'h01)];

  always_ff @(posedge mclk) begin
    if (stk.push && !push_ovf) begin
      stack_mem[sp_r[3:0]] <= stk.ret_pc;
    end
    if (do_wr && use_gpr && gpr_idx < 12'(core_mem_pkg::BANKS *
        core_mem_pkg::GPR_BYTES)) begin
      general_ram[gpr_idx] <= req.wdata;
    end
    if (do_wr && use_com) begin
      common[com_idx] <= req.wdata;
    end
  end

  wire core_wr = do_wr && use_core;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sp_r <= 5'h00;
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
      srst_r <= 1'b0;
      pm_st_r <= ST_IDLE;
      rdata_r <= 8'h00;
      status_r <= core_mem_pkg::STATUS_RST;
      {ptr0_r, ptr1_r} <= 32'h0000_0000;
      {bsr_r, working_register_r, program_counter_latch_high_r, interrupt_control_r} <= 32'h0000_0000;
      // RULE7 reset vector
      pc_r <= core_mem_pkg::RESET_VEC;
      {sh_status_r, sh_working_register_r, sh_bsr_r, sh_program_counter_latch_high_r} <= 32'h0000_0000;
      {sh_ptr0_r, sh_ptr1_r} <= 32'h0000_0000;
    end else begin
      pm_st_r <= pm_st_nxt;
      rdata_r <= rdata_nxt;
      // set wins over clear
      ovf_r <= push_ovf | (ovf_r & ~flag_clear[0]);
      unf_r <= pop_unf | (unf_r & ~flag_clear[1]);
      srst_r <= (push_ovf | pop_unf) & stack_reset_enable;
      if (stk.push && !push_ovf) begin
        sp_r <= sp_r + 5'h01;
      end else if (stk.pop && !pop_unf) begin
        sp_r <= sp_r - 5'h01;
      end
      status_r <= st_nxt;
      // RULE5 RULE6 RULE7 program counter
      if (irq_take) begin
        pc_r <= core_mem_pkg::IRQ_VEC;
      end else if (core_wr && off == core_mem_pkg::OFF_PCL) begin
        pc_r <= wrap_pc({program_counter_latch_high_r[6:0], req.wdata});
      end else if (!stall) begin
        pc_r <= wrap_pc(pc_next);
      end
      if (core_wr) begin
        unique case (off)
          core_mem_pkg::OFF_PTR0L: ptr0_r[7:0] <= req.wdata;
          core_mem_pkg::OFF_PTR0H: ptr0_r[15:8] <= req.wdata;
          core_mem_pkg::OFF_PTR1L: ptr1_r[7:0] <= req.wdata;
          core_mem_pkg::OFF_PTR1H: ptr1_r[15:8] <= req.wdata;
          core_mem_pkg::OFF_BSR: bsr_r <= {3'h0, req.wdata[4:0]};
          core_mem_pkg::OFF_WORKING_REGISTER: working_register_r <= req.wdata;
          core_mem_pkg::OFF_PROGRAM_COUNTER_LATCH_HIGH: program_counter_latch_high_r <= {1'b0, req.wdata[6:0]};
          core_mem_pkg::OFF_INTERRUPT_CONTROL: interrupt_control_r <= req.wdata;
          default: ;
        endcase
      end else if (pm_st_r == ST_PMWAIT) begin
        // RULE9 program low byte to working register
        working_register_r <= pm_data[7:0];
      end
      // RULE21 shadow save and restore
      if (irq_take) begin
        sh_status_r <= status_r;
        sh_working_register_r <= working_register_r;
        sh_bsr_r <= bsr_r;
        sh_program_counter_latch_high_r <= program_counter_latch_high_r;
        sh_ptr0_r <= ptr0_r;
        sh_ptr1_r <= ptr1_r;
      end else if (irq_return) begin
        status_r <= {st_nxt[7:3], sh_status_r[2:0]};
        working_register_r <= sh_working_register_r;
        bsr_r <= sh_bsr_r;
        program_counter_latch_high_r <= sh_program_counter_latch_high_r;
        ptr0_r <= sh_ptr0_r;
        ptr1_r <= sh_ptr1_r;
      end
    end
  end

  assign pc = pc_r;
  assign soft_reset = srst_r;
  assign stack_overflow_flag = ovf_r;
  assign stack_underflow_flag = unf_r;

  // RULE2 overflow flag follows fault
  a_ovf_flag_set: assert property (@(posedge mclk) disable iff (!rst_n)
    push_ovf |=> stack_overflow_flag) else $error("overflow flag not set");
  // RULE2 no reset on underflow unless enabled
  a_soft_reset_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    (pop_unf && !stack_reset_enable) |=> !soft_reset)
    else $error("soft reset without enable");
  // RULE7 interrupt vector
  a_irq_vector: assert property (@(posedge mclk) disable iff (!rst_n)
    irq_take |=> pc == 15'h0004) else $error("bad interrupt vector");
  // RULE4 extra cycle on program read
  a_pm_extra_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
    stall |=> !stall ##0 pm_st_r == ST_PMWAIT)
    else $error("program read not stretched");
  // RULE9 low byte returned
  a_pm_low_byte: assert property (@(posedge mclk) disable iff (!rst_n)
    pm_st_r == ST_PMWAIT |=> rdata == $past(pm_data[7:0]))
    else $error("program byte not returned");
  // RULE18 top bits always zero
  a_status_top_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    status_r[7:5] == 3'h0) else $error("status upper bits set");
  // RULE17 timeout ignores writes
  a_to_write_block: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_wr && !wdt_expire && !wdt_clear && !sleep_exec && !irq_return)
    |=> $stable(status_r[4:3])) else $error("timeout flag written");
  // RULE6 wraparound
  a_pc_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
    (pc & ~pm_top) == 15'h0000) else $error("pc outside implemented");
  // RULE1 stack pointer bound
  a_sp_bound: assert property (@(posedge mclk) disable iff (!rst_n)
    sp_r <= 5'd16) else $error("stack pointer beyond depth");

  c_pm_read: cover property (@(posedge mclk) disable iff (!rst_n) stall);
  c_overflow: cover property (@(posedge mclk) disable iff (!rst_n) push_ovf);
  c_irq: cover property (@(posedge mclk) disable iff (!rst_n)
    irq_take ##[1:20] irq_return);
endmodule : core_memory_addressing
`default_nettype wire

// ---- sim/pm_sfr_model.sv ----
// model of the program memory and peripheral registers beyond the block
// assumes one core clock; reads always answer, there is no write path
`timescale 1ns/100ps
`default_nettype none
module pm_sfr_model (
  // clock
  input wire logic mclk,
  // program memory
  input wire logic [14:0] pm_addr,
  input wire logic pm_rd,
  output logic [13:0] pm_data,
  // peripheral registers
  input wire logic [11:0] sfr_addr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata
);
  logic [7:0] noise_r = 8'h5A;
  // word per address, read only
  // unread cycles show a moving pattern so stale data cannot pass
  always_ff @(posedge mclk) begin
    noise_r <= noise_r + 8'h3B;
    pm_data <= pm_rd ? {6'h15, pm_addr[7:0] ^ 8'h3C} : {6'h2A, noise_r};
  end
  assign sfr_rdata = sfr_rd ? (sfr_addr[7:0] ^ 8'hC3) : noise_r;
endmodule : pm_sfr_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// testbench: drives the block as the execution pipeline would
// assumes pm_sfr_model answers the program memory and peripheral ports
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import core_mem_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  dmem_req_t req = '0;
  stack_req_t stk = '0;
  logic irq_take = 1'b0, irq_return = 1'b0, rst_en = 1'b0;
  logic wdt_expire = 1'b0, wdt_clear = 1'b0, sleep_exec = 1'b0;
  logic [1:0] flag_clear = 2'h0;
  logic [14:0] pc_next = 15'h0000;
  logic [7:0] rdata, sfr_wdata, sfr_rdata;
  logic [14:0] stack_top, pc, pm_addr, s_pm;
  logic [13:0] pm_data;
  logic [11:0] sfr_addr, s_sfr;
  logic stall, soft_reset, ovf, unf, pm_rd, hef, sfr_rd, sfr_wr;
  logic s_st, s_pr, s_hef, s_sw, seen;
  int num_errors = 0;
  int checked = 0;
  always #2 mclk = ~mclk;
  core_memory_addressing core_memory_addressing_inst (.mclk(mclk),
    .rst_n(rst_n), .req(req), .rdata(rdata), .stall(stall), .stk(stk),
    .stack_top(stack_top), .irq_take(irq_take), .irq_return(irq_return),
    .pc_next(pc_next), .pc(pc), .stack_rst_en_in_unused(),
    .stack_reset_enable(rst_en), .soft_reset(soft_reset),
    .stack_overflow_flag(ovf), .stack_underflow_flag(unf),
    .flag_clear(flag_clear), .wdt_expire(wdt_expire),
    .wdt_clear(wdt_clear), .sleep_exec(sleep_exec), .pm_addr(pm_addr),
    .pm_rd(pm_rd), .pm_data(pm_data), .pm_in_hef(hef),
    .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
  pm_sfr_model pm_sfr_model_inst (.mclk(mclk), .pm_addr(pm_addr),
    .pm_rd(pm_rd), .pm_data(pm_data), .sfr_addr(sfr_addr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata));

  task automatic chk(input logic [15:0] s, input logic [15:0] e,
                     input string what);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, e, s);
    end
  endtask : chk

  // one access; port outputs are captured early in its first cycle
  task automatic acc(input logic r, input logic w, input logic [6:0] a,
                     input logic [7:0] d, input logic af = 1'b0,
                     input logic [2:0] f = 3'h0);
    @(posedge mclk);
    req <= '{rd: r, wr: w, addr: a, wdata: d, alu_flags: af, flags: f};
    #1;
    {s_st, s_pr, s_hef, s_sw, s_pm, s_sfr} =
      {stall, pm_rd, hef, sfr_wr, pm_addr, sfr_addr};
    @(posedge mclk);
    while (stall === 1'b1) @(posedge mclk);
    req <= '0;
    #1;
  endtask : acc

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e,
                        input string what);
    acc(1'b1, 1'b0, a, 8'h00);
    chk(rdata, e, what);
  endtask : rd_chk

  task automatic ptr(input logic [6:0] hi_off, input logic [15:0] v);
    acc(1'b0, 1'b1, hi_off, v[15:8]);
    acc(1'b0, 1'b1, hi_off - 7'h01, v[7:0]);
  endtask : ptr

  task automatic t_status;
    chk(pc, RESET_VEC, "pc after reset");
    rd_chk(OFF_STATUS, STATUS_RST, "status reset");
    acc(1'b0, 1'b1, OFF_STATUS, 8'hFF);
    rd_chk(OFF_STATUS, 8'h1F, "status plain write");
    acc(1'b0, 1'b1, OFF_STATUS, 8'h00, 1'b1, 3'b110);
    rd_chk(OFF_STATUS, 8'h1E, "status clear");
    acc(1'b0, 1'b1, OFF_STATUS, 8'hE6, 1'b1, 3'b001);
    rd_chk(OFF_STATUS, 8'h19, "status alu write");
    @(posedge mclk) wdt_expire <= 1'b1;
    @(posedge mclk) wdt_expire <= 1'b0;
    rd_chk(OFF_STATUS, 8'h09, "status wdt expire");
    @(posedge mclk) sleep_exec <= 1'b1;
    @(posedge mclk) sleep_exec <= 1'b0;
    rd_chk(OFF_STATUS, 8'h11, "status sleep");
    @(posedge mclk) wdt_clear <= 1'b1;
    @(posedge mclk) wdt_clear <= 1'b0;
    rd_chk(OFF_STATUS, 8'h19, "status wdt clear");
    $display("test status done");
  endtask : t_status

  task automatic t_banks;
    acc(1'b0, 1'b1, OFF_BSR, 8'h05);
    acc(1'b0, 1'b1, 7'h0C, 8'h3C);
    chk({s_sw, s_sfr}, 16'h128C, "peripheral write address");
    rd_chk(7'h1F, 8'h5C, "peripheral read");
    chk(s_sfr, 12'h29F, "peripheral read address");
    acc(1'b0, 1'b1, OFF_WORKING_REGISTER, 8'h77);
    acc(1'b0, 1'b1, 7'h70, 8'h66);
    acc(1'b0, 1'b1, OFF_BSR, 8'h1F);
    rd_chk(OFF_WORKING_REGISTER, 8'h77, "core register in bank 31");
    rd_chk(7'h70, 8'h66, "common ram in bank 31");
    ptr(OFF_PTR0H, 16'h2050);
    acc(1'b0, 1'b1, OFF_INDIRECT_DATA_0, 8'hAB);
    acc(1'b0, 1'b1, OFF_BSR, 8'h01);
    rd_chk(7'h20, 8'hAB, "linear ram in bank 1");
    rd_chk(OFF_PTR0H, 8'h20, "pointer high");
    ptr(OFF_PTR0H, LIN_TOP);
    acc(1'b0, 1'b1, OFF_INDIRECT_DATA_0, 8'h5A);
    rd_chk(OFF_INDIRECT_DATA_0, 8'h5A, "linear ram top");
    ptr(OFF_PTR0H, LIN_TOP + 16'h0001);
    rd_chk(OFF_INDIRECT_DATA_0, 8'h00, "unimplemented read");
    $display("test banks done");
  endtask : t_banks

  task automatic t_progmem;
    ptr(OFF_PTR1H, 16'h8405);
    rd_chk(OFF_INDIRECT_DATA_1, 8'h39, "program read data");
    chk({s_st, s_pr, s_pm[13:0]}, 16'hC005, "program read start");
    rd_chk(OFF_WORKING_REGISTER, 8'h39, "program read to working_register");
    acc(1'b0, 1'b1, OFF_INDIRECT_DATA_1, 8'hFF);
    rd_chk(OFF_INDIRECT_DATA_1, 8'h39, "program write dropped");
    chk(s_pm, 15'h0005, "program address wrap");
    ptr(OFF_PTR1H, 16'h8380);
    rd_chk(OFF_INDIRECT_DATA_1, 8'hBC, "high endurance read");
    chk(s_hef, 1'b1, "high endurance start");
    ptr(OFF_PTR1H, 16'h837F);
    rd_chk(OFF_INDIRECT_DATA_1, 8'h43, "below high endurance");
    chk(s_hef, 1'b0, "below high endurance flag");
    $display("test program memory done");
  endtask : t_progmem

  task automatic t_flow;
    @(posedge mclk) pc_next <= 15'h7FFF;
    @(posedge mclk);
    #1;
    chk(pc, PM_MASK_SMALL, "pc width");
    acc(1'b0, 1'b1, OFF_WORKING_REGISTER, 8'h11);
    @(posedge mclk) irq_take <= 1'b1;
    @(posedge mclk) irq_take <= 1'b0;
    #1;
    chk(pc, IRQ_VEC, "interrupt vector");
    acc(1'b0, 1'b1, OFF_WORKING_REGISTER, 8'h22);
    @(posedge mclk) irq_return <= 1'b1;
    @(posedge mclk) irq_return <= 1'b0;
    rd_chk(OFF_WORKING_REGISTER, 8'h11, "working_register restored");
    $display("test flow done");
  endtask : t_flow

  task automatic push_pop(input logic pu, input logic [14:0] v);
    @(posedge mclk) stk <= '{push: pu, pop: ~pu, ret_pc: v};
    @(posedge mclk) stk <= '0;
    #1;
  endtask : push_pop

  task automatic t_stack;
    for (int i = 0; i < STACK_DEPTH; i++) push_pop(1'b1, 15'h7F00 + i);
    chk({unf, ovf, stack_top[13:0]}, 16'h3F0F, "full stack");
    for (int i = STACK_DEPTH - 1; i >= 0; i--) begin
      chk(stack_top, 15'h7F00 + i, "stack order");
      push_pop(1'b0, 15'h0000);
    end
    push_pop(1'b0, 15'h0000);
    chk({soft_reset, unf}, 2'b01, "underflow flag");
    @(posedge mclk) flag_clear <= 2'b10;
    @(posedge mclk) flag_clear <= 2'b00;
    rst_en <= 1'b1;
    for (int i = 0; i <= STACK_DEPTH; i++) push_pop(1'b1, 15'h0100);
    seen = soft_reset;
    repeat (3) @(posedge mclk) seen = seen | soft_reset;
    chk({seen, ovf}, 2'b11, "overflow reset");
    $display("test stack done");
  endtask : t_stack

  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    t_status();
    t_banks();
    t_progmem();
    t_flow();
    t_stack();
    report_and_stop();
  end

  // the tests take well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
